/* hw/frw_ctrl.sv */
// frw_ctrl: ahb read path of the flash controller with read-while-write handling and wait emulation.
// assumes ahb master and both flash banks on pclk; the addressed bank drives array_rdata and array_rvalid.
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module frw_ctrl
  import frw_pkg::*;
(
  input  wire logic        pclk,              // system clock
  input  wire logic        presetn,           // async reset, active low
  input  wire logic        hsel,              // flash selected
  input  wire logic [31:0] haddr,             // ahb address
  input  wire logic [1:0]  htrans,            // ahb transfer type
  input  wire logic        hwrite,            // ahb write
  input  wire logic        hready_in,         // ahb bus ready
  output logic             hready_out,        // ahb data phase ready
  output logic             hresp,             // ahb response, 1 = error
  output logic [31:0]      hrdata,            // ahb read data
  input  wire logic [1:0]  array_done,        // bank idle, low while busy
  input  wire logic [31:0] array_rdata,       // read data of addressed bank
  input  wire logic        array_rvalid,      // read data valid pulse
  output logic [31:0]      array_addr,        // address to the array
  output logic [1:0]       array_read_enable, // per-bank read request pulse
  output logic [1:0]       array_abort,       // per-bank operation abort
  output logic             buffer_invalidate, // page buffer invalidate pulse
  output logic             prefetch_inhibit,  // no prefetch, ignore buffer hits
  output logic             flash_irq,         // combined notification request
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb enable
  input  wire logic        pwrite,            // apb write
  input  wire logic [11:0] paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic [31:0]      prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr            // apb error, unmapped address
);

  typedef struct packed {
    frw_state_t  st;
    logic        bank;
    logic [31:0] addr;
    logic [4:0]  emu_cnt;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic [1:0]  rd_en;
    logic [1:0]  abort;
    logic        inval;
    logic        pf_inh;
    logic [2:0]  rww0;
    logic [2:0]  rww1;
    logic [7:0]  flags;
    logic        irq;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } frw_regs_t;

  frw_regs_t s_reg;
  frw_regs_t s_next;

  function automatic logic [4:0] emu_waits(input logic [31:0] a);
    emu_waits = {a[25:24], 3'h0} + {2'h0, a[28:26]};
  endfunction

  function automatic logic reg_mapped(input logic [11:0] a);
    reg_mapped = (a == FRW_CTRL_OFS) || (a == FRW_FLAGS_OFS) || (a == FRW_STATUS_OFS);
  endfunction

  // mode decode: top bit selects stall, the lower bits turn abort and notify off
  function automatic logic mode_stalls(input logic [2:0] m);
    mode_stalls = m[FRW_MODE_STALL];
  endfunction

  function automatic logic mode_aborts(input logic [2:0] m);
    mode_aborts = m[FRW_MODE_STALL] && !m[FRW_MODE_NO_ABORT];
  endfunction

  function automatic logic mode_notifies(input logic [2:0] m);
    mode_notifies = m[FRW_MODE_STALL] && !m[FRW_MODE_NO_NOTE];
  endfunction

  // flag of one bank: termination when the operation is cut, stall otherwise
  function automatic logic [7:0] flag_bit(input logic bank, input logic term);
    logic [7:0] f;
    f = 8'h00;
    if (term) begin
      f[bank ? FRW_B1_TERM_BIT : FRW_B0_TERM_BIT] = 1'b1;
    end else begin
      f[bank ? FRW_B1_STALL_BIT : FRW_B0_STALL_BIT] = 1'b1;
    end
    flag_bit = f;
  endfunction

  // bank 1 sits above the bank select address bit
  function automatic logic bank_of(input logic [31:0] a);
    bank_of = a[FRW_BANK_SEL_BIT];
  endfunction

  // register read mux; unmapped offsets read zero
  function automatic logic [31:0] read_word(input logic [11:0] a, input frw_regs_t r, input logic [1:0] done);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      FRW_CTRL_OFS: begin
        w[FRW_RWW0_LSB +: 3] = r.rww0;
        w[FRW_RWW1_LSB +: 3] = r.rww1;
      end
      FRW_FLAGS_OFS: begin
        w[7:0] = r.flags;
      end
      FRW_STATUS_OFS: begin
        w[FRW_ST_DONE_LSB +: 2]  = done;
        w[FRW_ST_ABORT_LSB +: 2] = r.abort;
        w[FRW_ST_STALL_BIT]      = (r.st == FRW_STALL);
        w[FRW_ST_EMU_BIT]        = r.pf_inh;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    read_word = w;
  endfunction

  // per-bank helpers
  logic [1:0] bank_idle;
  logic [1:0] abort_keep;

  for (genvar g = 0; g < 2; g++) begin : gen_bank
    assign bank_idle[g]  = array_done[g];
    // abort held while that bank is still busy
    assign abort_keep[g] = s_reg.abort[g] && !array_done[g];
  end

  logic       addr_phase;
  logic       nonseq;
  logic       emu_nz;
  logic       bank_busy;
  logic       enter_busy;
  logic [2:0] mode;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [4:0] waits;
  logic       accept;
  logic       apb_setup;
  logic       apb_wr_acc;

  // read flow: idle, optional emulated waits, request, wait for data.
  // a busy bank seen in request or wait turns into stall or error by mode.
  // the busy check follows the emulated waits, so a bank that goes busy
  // during them is still caught before the array sees the read.
  always_comb begin
    s_next     = s_reg;
    flag_set   = 8'h00;
    flag_clr   = 8'h00;
    enter_busy = 1'b0;
    waits      = emu_waits(haddr);
    addr_phase = hsel && hready_in && htrans[1];
    nonseq     = (htrans == FRW_HTRANS_NONSEQ);
    emu_nz     = |haddr[FRW_EMU_HI:FRW_EMU_LO];
    accept     = addr_phase && s_reg.hready;
    apb_setup  = psel && !penable;
    apb_wr_acc = psel && penable && s_reg.pready && pwrite && !s_reg.pslverr;
    bank_busy  = ~bank_idle[s_reg.bank];
    mode       = s_reg.bank ? s_reg.rww1 : s_reg.rww0;
    s_next.rd_en = 2'h0;
    s_next.inval = 1'b0;

    s_next.abort = abort_keep;

    unique case (s_reg.st)
      FRW_IDLE: begin
        // second error cycle ends here
        s_next.hresp = 1'b0;
        // next address taken only while hready is high
        if (accept) begin
          s_next.addr = haddr;
          s_next.bank = bank_of(haddr);
          s_next.pf_inh = emu_nz;
          s_next.inval = nonseq && emu_nz;
          if (!hwrite) begin
            s_next.hready = 1'b0;
            // only first beat of burst or single
            if (nonseq && (waits != 5'h00)) begin
              s_next.emu_cnt = waits;
              s_next.st      = FRW_EMU;
            end else begin
              s_next.st = FRW_REQ;
            end
          end
          // writes complete with no wait, write path lies elsewhere
        end
      end
      FRW_EMU: begin
        s_next.emu_cnt = s_reg.emu_cnt - 5'h01;
        if (s_reg.emu_cnt == 5'h01) begin
          s_next.st = FRW_REQ;
        end
      end
      FRW_REQ: begin
        if (bank_busy) begin
          enter_busy = 1'b1;
        end else begin
          // replay latched address with read enable
          s_next.rd_en[s_reg.bank] = 1'b1;
          s_next.st                = FRW_WAIT;
        end
      end
      FRW_WAIT: begin
        if (bank_busy) begin
          // done fell while read in progress
          enter_busy = 1'b1;
        end else if (array_rvalid) begin
          s_next.hrdata = array_rdata;
          s_next.hready = 1'b1;
          s_next.st     = FRW_IDLE;
        end
      end
      FRW_STALL: begin
        // hold ready low until the operation ends
        if (!bank_busy) begin
          s_next.st = FRW_REQ;
        end
      end
      FRW_ERR: begin
        // second error cycle with ready high
        s_next.hready = 1'b1;
        s_next.st     = FRW_IDLE;
      end
      default: begin
        // unused state codes fall back to idle with the bus released
        s_next.hready = 1'b1;
        s_next.hresp  = 1'b0;
        s_next.st     = FRW_IDLE;
      end
    endcase

    if (enter_busy) begin
      if (!mode_stalls(mode)) begin
        // error; when raised in request, the array never sees the read
        s_next.hresp = 1'b1;
        s_next.st    = FRW_ERR;
      end else begin
        // stall with address held in addr
        s_next.st = FRW_STALL;
        // abort on first sight of busy
        if (mode_aborts(mode)) begin
          s_next.abort[s_reg.bank] = 1'b1;
        end
        if (mode_notifies(mode)) begin
          flag_set = flag_bit(s_reg.bank, mode_aborts(mode));
        end
      end
    end

    // apb: setup cycle decodes, one access cycle with ready high
    s_next.pready  = 1'b0;
    s_next.pslverr = 1'b0;
    if (apb_setup) begin
      s_next.pready  = 1'b1;
      s_next.pslverr = !reg_mapped(paddr);
      s_next.prdata  = 32'h0000_0000;
      if (!pwrite) begin
        s_next.prdata = read_word(paddr, s_reg, array_done);
      end
    end

    // write lands only at the access edge, never at setup
    if (apb_wr_acc) begin
      if (paddr == FRW_CTRL_OFS) begin
        s_next.rww0 = pwdata[FRW_RWW0_LSB +: 3];
        s_next.rww1 = pwdata[FRW_RWW1_LSB +: 3];
      end
      if (paddr == FRW_FLAGS_OFS) begin
        flag_clr = pwdata[7:0] & FRW_FLAGS_MASK;
      end
    end

    // flags captured, set wins over write-one clear
    s_next.flags = ((s_reg.flags & ~flag_clr) | flag_set) & FRW_FLAGS_MASK;
    s_next.irq = |s_next.flags;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg         <= '0;
      s_reg.st      <= FRW_IDLE;
      s_reg.hready  <= 1'b1;
      s_reg.rww0    <= FRW_RWW_RESET;
      s_reg.rww1    <= FRW_RWW_RESET;
      s_reg.flags   <= FRW_FLAGS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops; fastest read is array latency plus two cycles
  assign hready_out        = s_reg.hready;
  assign hresp             = s_reg.hresp;
  assign hrdata            = s_reg.hrdata;
  assign array_addr        = s_reg.addr;
  assign array_read_enable = s_reg.rd_en;
  assign array_abort       = s_reg.abort;
  assign buffer_invalidate = s_reg.inval;
  assign prefetch_inhibit  = s_reg.pf_inh;
  assign flash_irq         = s_reg.irq;
  assign prdata            = s_reg.prdata;
  assign pready            = s_reg.pready;
  assign pslverr           = s_reg.pslverr;

endmodule

/* include/frw_pkg.sv */
// frw_pkg: constants and types for the flash read-while-write and wait-emulation controller.
// assumes one system clock and an APB slave port for the control and flag registers.
package frw_pkg;

  // apb register byte offsets
  localparam logic [11:0] FRW_CTRL_OFS   = 12'h000;
  localparam logic [11:0] FRW_FLAGS_OFS  = 12'h004;
  localparam logic [11:0] FRW_STATUS_OFS = 12'h008;

  // control register field positions
  localparam int FRW_RWW0_LSB = 0;
  localparam int FRW_RWW1_LSB = 4;

  // response mode field: mode[2]=stall, mode[1]=no abort, mode[0]=no notify
  localparam logic [2:0] FRW_RWW_RESET = 3'h7;
  localparam int FRW_MODE_STALL    = 2;
  localparam int FRW_MODE_NO_ABORT = 1;
  localparam int FRW_MODE_NO_NOTE  = 0;

  // system interrupt flag positions
  localparam int FRW_B0_TERM_BIT  = 7;
  localparam int FRW_B0_STALL_BIT = 6;
  localparam int FRW_B1_TERM_BIT  = 5;
  localparam int FRW_B1_STALL_BIT = 4;
  localparam logic [7:0] FRW_FLAGS_MASK  = 8'hF0;
  localparam logic [7:0] FRW_FLAGS_RESET = 8'h00;

  // status register field positions
  localparam int FRW_ST_DONE_LSB  = 0;
  localparam int FRW_ST_ABORT_LSB = 2;
  localparam int FRW_ST_STALL_BIT = 4;
  localparam int FRW_ST_EMU_BIT   = 5;

  // ahb address fields
  localparam int FRW_BANK_SEL_BIT = 23;
  localparam int FRW_EMU_HI       = 28;
  localparam int FRW_EMU_LO       = 24;
  localparam logic [1:0] FRW_HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    FRW_IDLE,
    FRW_EMU,
    FRW_REQ,
    FRW_WAIT,
    FRW_STALL,
    FRW_ERR
  } frw_state_t;

endpackage

/* test/frw_ctrl_bench.sv */
// frw_ctrl_bench: directed tests of read-while-write responses and wait emulation.
// assumes the flash model keeps a bank busy 40 cycles unless aborted.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module frw_ctrl_bench;
  import frw_pkg::*;
  logic        pclk = 0, presetn = 0, hsel = 0, hwrite = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] haddr = 0, pwdata = 0, hrdata, array_rdata, array_addr, prdata, rd, pd;
  logic [1:0]  htrans = 0, array_done, array_read_enable, array_abort, busy_set = 0, ab;
  logic [11:0] paddr = 0;
  logic        hready_out, hresp, array_rvalid, buffer_invalidate, prefetch_inhibit;
  logic        flash_irq, pready, pslverr, pe, rs;
  wire logic   hready_in = hready_out;
  int          err_total = 0, check_count = 0, n;
  always #4 pclk = ~pclk;
  frw_ctrl frw_ctrl_i (.*);
  frw_flash_model frw_flash_model_i (.*);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk) begin psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; end
    @(posedge pclk) penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    pd = prdata;
    pe = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic ahb(input logic w, input logic [1:0] t, input logic [31:0] a);
    @(posedge pclk) begin htrans <= t; haddr <= a; hwrite <= w; hsel <= 1; end
    @(posedge pclk) htrans <= 2'h0;
    n = 0;
    ab = 0;
    do begin @(posedge pclk); n++; ab |= array_abort; end while (hready_out !== 1'b1 && n < 200);
    rd = hrdata;
    rs = hresp;
  endtask
  task automatic t_reset;
    apb(0, FRW_CTRL_OFS, 0);   `CHK("ctrl", 32'h0000_0077, pd)
    apb(0, FRW_FLAGS_OFS, 0);  `CHK("flags", 32'h0, pd)
    apb(0, FRW_STATUS_OFS, 0); `CHK("status", 32'h0000_0003, pd)
    apb(0, 12'h00C, 0);        `CHK("unmapped", 1'b1, pe)
  endtask
  task automatic t_plain;
    ahb(0, 2'h2, 32'h0000_0100);
    `CHK("data", 32'h5A5A_0100, rd)
    `CHK("latency", 4, n)
  endtask
  task automatic t_emu;
    ahb(0, 2'h2, 32'h0D00_0040); `CHK("emu waits", 15, n)
    `CHK("emu data", 32'h575A_0040, rd)
    apb(0, FRW_STATUS_OFS, 0);   `CHK("inhibit", 32'h0000_0023, pd)
    ahb(0, 2'h2, 32'h1F00_0000); `CHK("max waits", 35, n)
    ahb(1, 2'h2, 32'h0D00_0040); `CHK("write", 1, n)
    ahb(0, 2'h3, 32'h0D00_0044); `CHK("seq beat", 4, n)
  endtask
  task automatic t_modes;
    logic [2:0] m;
    logic [7:0] f;
    for (int b = 0; b < 2; b++) for (int i = 0; i < 8; i++) begin
      m = 3'h7 - 3'(i);
      f = (m == 3'h6) ? (8'h40 >> (2 * b)) : (m == 3'h4) ? (8'h80 >> (2 * b)) : 8'h00;
      apb(1, FRW_CTRL_OFS, b ? {25'h0, m, 4'h7} : {25'h0, 3'h7, 1'b0, m});
      @(posedge pclk) busy_set[b] <= 1'b1;
      @(posedge pclk) busy_set <= 2'h0;
      ahb(0, 2'h2, b ? 32'h0080_0200 : 32'h0000_0200);
      `CHK("resp", !m[2], rs)
      if (m[2]) `CHK("retry data", b ? 32'h5ADA_0200 : 32'h5A5A_0200, rd)
      `CHK("abort", m[2:1] == 2'b10, ab[b])
      `CHK("long stall", m[2:1] == 2'b11, n > 30)
      apb(0, FRW_FLAGS_OFS, 0);  `CHK("flag bits", {24'h0, f}, pd)
      `CHK("irq", f != 8'h00, flash_irq)
      apb(1, FRW_FLAGS_OFS, 32'h0000_00F0);
      n = 0;
      while (array_done !== 2'h3 && n < 100) begin @(posedge pclk); n++; end
    end
    apb(0, FRW_FLAGS_OFS, 0);    `CHK("cleared", 32'h0, pd)
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_plain;
    t_emu;
    t_modes;
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    end_of_test;
  end
endmodule
bind frw_ctrl frw_ctrl_properties frw_ctrl_properties_i (.*);

/* test/frw_ctrl_properties.sv */
// frw_ctrl_properties: timing checks on the ahb read path and the array handshake.
// assumes the bench keeps both banks idle around emulated-wait reads.
`timescale 1ns/1ps
module frw_ctrl_properties (
  input wire logic        pclk, presetn, hsel, hwrite, hready_in, hready_out, hresp,
  input wire logic [31:0] haddr, hrdata, array_rdata,
  input wire logic [1:0]  htrans, array_done, array_read_enable, array_abort,
  input wire logic        array_rvalid, buffer_invalidate, prefetch_inhibit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = hsel & hready_in & htrans[1] & hready_out;
  AST_ERR_SHAPE: assert property (
    $rose(hresp) |-> !hready_out ##1 (hresp && hready_out) ##1 !hresp) else $error("bad error response");
  AST_ERR_BLOCK: assert property (
    hresp |-> array_read_enable == 2'h0) else $error("array read during error");
  AST_RD_IDLE: assert property (
    (array_read_enable & ~$past(array_done)) == 2'h0) else $error("array read to busy bank");
  AST_ABORT_HOLD: assert property (
    (array_abort & ~array_done) != 2'h0 |=> (array_abort & $past(array_abort & ~array_done))
      == $past(array_abort & ~array_done)) else $error("abort dropped while busy");
  AST_ABORT_CLR: assert property (
    (array_abort & array_done & $past(array_done)) == 2'h0) else $error("abort held after done");
  AST_ABORT_CAUSE: assert property (
    (array_abort & ~$past(array_abort) & $past(array_done)) == 2'h0) else $error("abort without busy");
  AST_DATA: assert property (
    $rose(hready_out) && !hresp |-> $past(array_rvalid) && hrdata == $past(array_rdata))
    else $error("read data not from array");
  AST_WR_FAST: assert property (
    acc && hwrite |=> hready_out) else $error("write lengthened");
  AST_ZERO_LAT: assert property (
    acc && !hwrite && haddr[28:24] == 5'h00 && array_done == 2'h3 ##1 array_done == 2'h3
      |-> ##1 array_read_enable != 2'h0) else $error("slow array request");
  AST_EMU: assert property (
    acc && !hwrite && htrans == 2'h2 && haddr[28:24] == 5'h0D |-> (array_read_enable == 2'h0)[*8]
      ##1 (array_read_enable == 2'h0)[*5] ##1 array_read_enable != 2'h0) else $error("wrong wait count");
  AST_INHIBIT: assert property (
    acc && haddr[28:24] != 5'h00 |=> prefetch_inhibit) else $error("prefetch not inhibited");
  AST_INVAL: assert property (
    acc && htrans == 2'h2 && haddr[28:24] != 5'h00 |-> ##[1:2] buffer_invalidate) else $error("no invalidate");
  COV_ERR: cover property (hresp && hready_out);
  COV_ABORT: cover property (array_abort != 2'h0);
  COV_EMU: cover property (acc && haddr[28:24] == 5'h0D);
endmodule

/* test/frw_flash_model.sv */
// frw_flash_model: two flash banks; data one cycle after the read enable.
// assumes busy_set pulses from the bench; abort cuts the busy time to two cycles.
`timescale 1ns/1ps
module frw_flash_model (
  input  wire logic        pclk,              // system clock
  input  wire logic        presetn,           // async reset, active low
  input  wire logic [1:0]  busy_set,          // start program/erase
  input  wire logic [1:0]  array_read_enable, // read request
  input  wire logic [1:0]  array_abort,       // abort request
  input  wire logic [31:0] array_addr,        // read address
  output logic      [1:0]  array_done,        // bank idle
  output logic      [31:0] array_rdata,       // read data
  output logic             array_rvalid       // data valid
);
  int cnt [2];
  always_comb for (int b = 0; b < 2; b++) array_done[b] = (cnt[b] == 0);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '{0, 0};
      array_rvalid <= 1'b0;
      array_rdata <= 32'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (busy_set[b]) cnt[b] <= 40;
        else if (array_abort[b] && cnt[b] > 2) cnt[b] <= 2;
        else if (cnt[b] > 0) cnt[b] <= cnt[b] - 1;
      end
      array_rvalid <= |array_read_enable;
      // data toggles outside the valid pulse so stale data never matches
      array_rdata <= (|array_read_enable) ? (array_addr ^ 32'h5A5A_0000) : ~array_rdata;
    end
  end
endmodule
